/* verilog/pdw_pkg.sv */
// Shared constants and types of the power-down, wake-up and watchdog block
`default_nettype none
package pdw_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int SYS_CLK_HZ      = 20_000_000;
  localparam int WAKE_DELAY_PER  = 1024;
  localparam int WAKE_DELAY_CYC  = WAKE_DELAY_PER;
  localparam int WAIT_W          = 10;
  localparam logic [WAIT_W-1:0] WAIT_LAST = 10'h3FF;

  // ****************************************
  // Watchdog divider
  // ****************************************
  localparam int PRESC_W = 6;
  localparam logic [PRESC_W-1:0] PRESC_MAX = 6'h3F;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONFIG  = 8'h04;
  localparam logic [7:0] ADDR_WAKE_A  = 8'h08;
  localparam logic [7:0] ADDR_WAKE_NB = 8'h0C;
  localparam logic [7:0] ADDR_AUX     = 8'h10;

  localparam int STS_TO  = 0;
  localparam int STS_PDF = 1;
  localparam int STS_ST  = 2;

  localparam int CFG_WDT_EN = 0;
  localparam int CFG_PAIRED = 1;
  localparam int CFG_SRC_RC = 2;
  localparam int CFG_RC_EN  = 3;
  localparam logic [3:0] CFG_RESET    = 4'hD;
  localparam logic [7:0] WAKE_A_RESET = 8'h00;
  localparam logic [3:0] WAKE_NB_RESET = 4'h0;
  localparam logic [7:0] AUX_RESET    = 8'h00;
  localparam int AUX_RC_LO = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAIT, ST_INTDLY} pdw_state_t;
  typedef enum logic [1:0] {WK_RES, WK_WDT, WK_INT, WK_PIN} pdw_cause_t;
  typedef enum logic [1:0] {HALF_NONE, HALF_FIRST, HALF_SECOND} pdw_half_t;

endpackage
`default_nettype wire

/* verilog/pdw_top.sv */
// Power-down entry, wake-up sequencing and watchdog timer
//
// Operation
// RULE1: Only the sleep instruction enters power-down.
// RULE2: Sleep stops the system oscillator and holds the core at that instruction.
// RULE3: Memory, registers and port states are kept during power-down.
// RULE4: Sleep clears watchdog; it runs on RC clock, stops on system clock.
// RULE5: Sleep sets the power-down flag and clears the timeout flag.
// RULE6: Wake on external reset, enabled pin fall, interrupt or watchdog overflow.
// RULE7: Reset-pin wake is full reset; watchdog wake is watchdog reset.
// RULE8: Power-down flag cleared by power-up or watchdog clear, set by sleep.
// RULE9: Watchdog timeout in sleep sets timeout flag, resets only PC and SP.
// RULE10: Port A pins or nibbles of other ports wake; execution continues after sleep.
// RULE11: Disabled or stack-full interrupt wake resumes after sleep; request stays pending.
// RULE12: Enabled interrupt with free stack level vectors after wake-up.
// RULE13: Interrupt already requested at sleep does not wake that period.
// RULE14: Any wake waits 1024 system clocks, then next instruction runs at once.
// RULE15: Interrupt wake delays routine entry at least one more cycle.
// RULE16: Watchdog overflow in normal operation resets device, sets timeout flag.
// RULE17: Watchdog disabled makes all watchdog instructions no-operations.
// RULE18: 6-bit divider then clearable one-bit stage; clears reset only that stage.
// RULE19: Watchdog cleared by reset pin low, clear instructions or sleep.
// RULE20: Option selects single or paired clearing; paired needs both halves.
// RULE21: Repeating one half has no effect; only the other half completes.
// RULE22: Upper three auxiliary register bits clear after firmware reads it.
// RULE23: RC oscillator keeps running in power-down unless option disables it.
// RULE24: Timeout in power-down leaves both timeout and power-down flags set.
// RULE25: Wake detection needs no core clock, oscillator restarts before delay.
`default_nettype none
module pdw_top (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic        sleepExec,
  input  wire logic        clrSingle,
  input  wire logic        clrFirst,
  input  wire logic        clrSecond,
  input  wire logic        extRst_n,
  input  wire logic        wdtOscPin,
  input  wire logic [7:0]  portA,
  input  wire logic [15:0] portHi,
  input  wire logic [3:0]  intReq,
  input  wire logic [3:0]  intEnable,
  input  wire logic        stackFull,
  output logic      [7:0]  regRdata_q,
  output logic             sysOscRun_q,
  output logic             rcOscRun_q,
  output logic             coreHold_q,
  output logic             chipReset_q,
  output logic             pcSpReset_q,
  output logic             intVector_q,
  output logic             resume_q,
  output logic             timeoutFlag_q,
  output logic             powerdownFlag_q
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SW = 26;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] prev_q;

  // Idle-high reset values so no false falling edge appears at release
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
    end else begin
      sync1_q <= {extRst_n, wdtOscPin, portA, portHi};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire        rstPinLow = ~sync2_q[25];
  wire        rstFall   = prev_q[25] & ~sync2_q[25];
  wire        oscRise   = sync2_q[24] & ~prev_q[24];
  wire [7:0]  curA      = sync2_q[23:16];
  wire [7:0]  oldA      = prev_q[23:16];
  wire [15:0] curHi     = sync2_q[15:0];
  wire [15:0] oldHi     = prev_q[15:0];

  function automatic logic [3:0] nibFall(input logic [15:0] o, input logic [15:0] c);
    logic [15:0] f;
    f = o & ~c;
    nibFall = {|f[15:12], |f[11:8], |f[7:4], |f[3:0]};
  endfunction

  // ****************************************
  // Registers written by software
  // ****************************************
  logic [3:0] cfg_q;
  logic [7:0] wakeA_q;
  logic [3:0] wakeNib_q;
  logic [7:0] aux_q;

  wire wdtEn   = cfg_q[pdw_pkg::CFG_WDT_EN];
  wire paired  = cfg_q[pdw_pkg::CFG_PAIRED];
  wire srcRc   = cfg_q[pdw_pkg::CFG_SRC_RC];
  wire rcEn    = cfg_q[pdw_pkg::CFG_RC_EN];
  wire wrCfg   = regWr & (regAddr == pdw_pkg::ADDR_CONFIG);
  wire wrWakeA = regWr & (regAddr == pdw_pkg::ADDR_WAKE_A);
  wire wrWakeN = regWr & (regAddr == pdw_pkg::ADDR_WAKE_NB);
  wire wrAux   = regWr & (regAddr == pdw_pkg::ADDR_AUX);
  wire rdAux   = regRd & (regAddr == pdw_pkg::ADDR_AUX);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q     <= pdw_pkg::CFG_RESET;
      wakeA_q   <= pdw_pkg::WAKE_A_RESET;
      wakeNib_q <= pdw_pkg::WAKE_NB_RESET;
      aux_q     <= pdw_pkg::AUX_RESET;
    end else begin
      if (wrCfg) cfg_q <= regWdata[3:0];
      if (wrWakeA) wakeA_q <= regWdata;
      if (wrWakeN) wakeNib_q <= regWdata[3:0];
      if (wrAux) aux_q <= regWdata;
      else if (rdAux) aux_q[7:pdw_pkg::AUX_RC_LO] <= 3'h0; // RULE22
    end
  end

  // ****************************************
  // Sequencer state
  // ****************************************
  pdw_pkg::pdw_state_t state_q;
  pdw_pkg::pdw_state_t state_d;
  pdw_pkg::pdw_cause_t cause_q;
  pdw_pkg::pdw_cause_t cause_d;
  localparam int WAIT_W_L = pdw_pkg::WAIT_W;
  pdw_pkg::pdw_half_t  half_q;
  logic [WAIT_W_L-1:0] waitCnt_q;
  logic [3:0]          intBlock_q;

  wire inRun   = (state_q == pdw_pkg::ST_RUN);
  wire inSleep = (state_q == pdw_pkg::ST_SLEEP);
  wire inWait  = (state_q == pdw_pkg::ST_WAIT);
  wire sleepGo = sleepExec & inRun; // RULE1
  wire waitEnd = inWait & (waitCnt_q == pdw_pkg::WAIT_LAST); // RULE14

  // ****************************************
  // Watchdog chain
  // ****************************************
  logic [pdw_pkg::PRESC_W-1:0] presc_q;
  logic                        stage_q;

  // System-clock source gives no ticks while the oscillator is stopped
  wire sysTick = ~inSleep; // RULE4
  wire rcTick  = oscRise & rcEn; // RULE23
  wire wdtTick = wdtEn & (srcRc ? rcTick : sysTick);
  wire pairDone = ((clrFirst & (half_q == pdw_pkg::HALF_SECOND)) |
                   (clrSecond & (half_q == pdw_pkg::HALF_FIRST))); // RULE21
  wire clrDone = wdtEn & inRun & (paired ? pairDone : clrSingle); // RULE17 RULE20
  wire wdtClr  = clrDone | (sleepGo & wdtEn) | rstPinLow; // RULE19
  wire prescWrap = wdtTick & (presc_q == pdw_pkg::PRESC_MAX);
  wire wdtOvf  = prescWrap & stage_q & ~wdtClr;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_q <= '0;
      stage_q <= 1'b0;
    end else begin
      if (rstPinLow) presc_q <= '0;
      else if (wdtTick) presc_q <= presc_q + 6'h01; // RULE18
      if (wdtClr) stage_q <= 1'b0; // RULE18
      else if (prescWrap) stage_q <= ~stage_q;
    end
  end

  // Paired clearing: remember which half came last
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_q <= pdw_pkg::HALF_NONE;
    end else if (~wdtEn | ~paired | clrDone) begin
      half_q <= pdw_pkg::HALF_NONE; // RULE20
    end else if (inRun & clrFirst) begin
      half_q <= pdw_pkg::HALF_FIRST; // RULE21
    end else if (inRun & clrSecond) begin
      half_q <= pdw_pkg::HALF_SECOND; // RULE21
    end
  end

  // ****************************************
  // Wake sources
  // ****************************************
  // Edges are taken on the always-running sample clock, not on the core clock
  wire pinWake = |(oldA & ~curA & wakeA_q) | |(nibFall(oldHi, curHi) & wakeNib_q); // RULE10 RULE25
  wire [3:0] armedInt = intReq & ~intBlock_q; // RULE13
  wire intWake = |armedInt;
  wire intTake = |(armedInt & intEnable) & ~stackFull; // RULE12

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) intBlock_q <= 4'h0;
    else if (sleepGo) intBlock_q <= intReq; // RULE13
  end

  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    unique case (state_q)
      pdw_pkg::ST_RUN: begin
        if (sleepGo & ~wdtOvf & ~rstFall) state_d = pdw_pkg::ST_SLEEP; // RULE1 RULE2
      end
      pdw_pkg::ST_SLEEP: begin
        state_d = pdw_pkg::ST_WAIT; // RULE6 RULE25
        if (rstFall) cause_d = pdw_pkg::WK_RES;
        else if (wdtOvf) cause_d = pdw_pkg::WK_WDT;
        else if (intWake) cause_d = pdw_pkg::WK_INT;
        else if (pinWake) cause_d = pdw_pkg::WK_PIN;
        else state_d = pdw_pkg::ST_SLEEP; // RULE3
      end
      pdw_pkg::ST_WAIT: begin
        if (waitEnd) begin
          if ((cause_q == pdw_pkg::WK_INT) & intTake) state_d = pdw_pkg::ST_INTDLY; // RULE15
          else state_d = pdw_pkg::ST_RUN;
        end
      end
      pdw_pkg::ST_INTDLY: state_d = pdw_pkg::ST_RUN; // RULE15
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= pdw_pkg::ST_RUN;
      cause_q   <= pdw_pkg::WK_PIN;
      waitCnt_q <= '0;
    end else begin
      state_q   <= state_d;
      cause_q   <= cause_d;
      waitCnt_q <= inWait ? waitCnt_q + 10'h001 : '0; // RULE14
    end
  end

  // ****************************************
  // Core controls and flags
  // ****************************************
  wire endRes = waitEnd & (cause_q == pdw_pkg::WK_RES);
  wire endWdt = waitEnd & (cause_q == pdw_pkg::WK_WDT);
  wire endGo  = waitEnd & (cause_q == pdw_pkg::WK_PIN |
                           (cause_q == pdw_pkg::WK_INT & ~intTake)); // RULE11
  wire sleepRes = inSleep & rstFall;
  wire toSet  = wdtOvf & (inRun | inSleep); // RULE9 RULE16
  wire toClr  = sleepGo | sleepRes;
  wire pdfClr = clrDone | sleepRes; // RULE8

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeoutFlag_q   <= 1'b0;
      powerdownFlag_q <= 1'b0; // RULE8
    end else begin
      // Hardware set wins over any clear in the same cycle
      if (toSet) timeoutFlag_q <= 1'b1; // RULE16 RULE24
      else if (toClr) timeoutFlag_q <= 1'b0; // RULE5
      if (sleepGo) powerdownFlag_q <= 1'b1; // RULE5 RULE8
      else if (pdfClr) powerdownFlag_q <= 1'b0; // RULE7
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysOscRun_q <= 1'b1;
      rcOscRun_q  <= 1'b1;
      coreHold_q  <= 1'b0;
      chipReset_q <= 1'b0;
      pcSpReset_q <= 1'b0;
      intVector_q <= 1'b0;
      resume_q    <= 1'b0;
    end else begin
      sysOscRun_q <= (state_d != pdw_pkg::ST_SLEEP); // RULE2 RULE25
      rcOscRun_q  <= rcEn; // RULE23
      coreHold_q  <= (state_d != pdw_pkg::ST_RUN); // RULE2 RULE3
      chipReset_q <= (inRun & (rstFall | wdtOvf)) | endRes; // RULE7 RULE16
      pcSpReset_q <= endWdt; // RULE7 RULE9
      intVector_q <= (state_q == pdw_pkg::ST_INTDLY); // RULE12 RULE15
      resume_q    <= endGo; // RULE10 RULE11 RULE14
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  wire [7:0] stsWord = {4'h0, state_q, powerdownFlag_q, timeoutFlag_q};
  wire [7:0] rdMux =
    (regAddr == pdw_pkg::ADDR_STATUS)  ? stsWord :
    (regAddr == pdw_pkg::ADDR_CONFIG)  ? {4'h0, cfg_q} :
    (regAddr == pdw_pkg::ADDR_WAKE_A)  ? wakeA_q :
    (regAddr == pdw_pkg::ADDR_WAKE_NB) ? {4'h0, wakeNib_q} :
    (regAddr == pdw_pkg::ADDR_AUX)     ? aux_q : 8'h00;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) regRdata_q <= 8'h00;
    else regRdata_q <= regRd ? rdMux : 8'h00;
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Cycles since a watchdog overflow ended a power-down; saturates so an old count never matches
  logic [10:0] ovfAge_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) ovfAge_q <= 11'h000;
    else if (inSleep & wdtOvf & ~rstFall) ovfAge_q <= 11'h001;
    else if (ovfAge_q != 11'h000 && ovfAge_q != 11'h7FF) ovfAge_q <= ovfAge_q + 11'h001;
  end

  a_sleep_entry_only: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
    inRun ##1 inSleep |-> $past(sleepExec)) else $error("power-down entered without sleep");
  a_osc_stopped: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
    inSleep |-> !sysOscRun_q && coreHold_q) else $error("oscillator runs in power-down");
  a_sleep_clears_wdt: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
    sleepGo && wdtEn |=> !stage_q) else $error("watchdog stage not cleared at sleep");
  a_sleep_flag_set: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
    sleepGo && !wdtOvf |=> powerdownFlag_q && !timeoutFlag_q) else $error("flags wrong after sleep");
  a_sleep_ovf_flags: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE24
    inSleep && wdtOvf && !rstFall |=> timeoutFlag_q && powerdownFlag_q)
    else $error("watchdog wake flags wrong");
  a_ovf_pcsp_reset: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9 RULE14
    ovfAge_q == 11'(pdw_pkg::WAKE_DELAY_CYC + 1) |-> pcSpReset_q)
    else $error("watchdog wake did not reset PC and SP on time");
  a_wait_holds: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
    inWait && waitCnt_q != pdw_pkg::WAIT_LAST |=> inWait && !resume_q)
    else $error("wake delay cut short");
  a_int_extra_cycle: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE15
    intVector_q |-> $past(state_q, 2) == pdw_pkg::ST_WAIT) else $error("vector without extra cycle");
  a_normal_ovf: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE16
    inRun && wdtOvf |=> chipReset_q && timeoutFlag_q) else $error("normal overflow not handled");
  a_disabled_nop: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE17
    !wdtEn |-> !wdtOvf && !clrDone) else $error("disabled watchdog acted");
  a_pair_repeat: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE21
    paired && half_q == pdw_pkg::HALF_FIRST && !clrSecond |-> !clrDone)
    else $error("repeated half cleared watchdog");
  a_aux_read_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE22
    rdAux && !regWr |=> aux_q[7:5] == 3'h0) else $error("aux upper bits not cleared");
  a_blocked_int: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE13
    inSleep && !rstFall && !wdtOvf && !pinWake && (intReq & ~intBlock_q) == 4'h0 |=> inSleep)
    else $error("blocked interrupt woke device");

  // Outcome of each wake source and of the clears
  a_pin_wake: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE10
    inSleep && pinWake && !rstFall && !wdtOvf && !intWake |=> inWait && cause_q == pdw_pkg::WK_PIN)
    else $error("pin edge did not start wake delay");
  a_run_reset_pin: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
    inRun && rstFall |=> chipReset_q) else $error("reset pin in run gave no reset");
  a_sleep_reset_flags: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
    sleepRes && !wdtOvf |=> !timeoutFlag_q && !powerdownFlag_q) else $error("reset wake flags wrong");
  a_hold_released: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
    resume_q || intVector_q || pcSpReset_q |-> !coreHold_q)
    else $error("core still held after wake");
  a_resume_after_wait: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
    resume_q |-> $past(inWait)) else $error("resume without wake delay");
  a_stack_full_no_vector: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
    intVector_q |-> !$past(stackFull, 2)) else $error("vector taken with full stack");
  a_pdf_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    clrDone && !sleepGo |=> !powerdownFlag_q) else $error("clear left power-down flag set");
  a_rc_osc_follows: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE23
    1'b1 |=> rcOscRun_q == $past(rcEn)) else $error("RC oscillator enable not followed");
  a_wdt_clear_stage: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE19
    wdtClr |=> !stage_q) else $error("watchdog stage not cleared");
  a_presc_pin_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE19
    rstPinLow |=> presc_q == 6'h00 && !stage_q) else $error("reset pin left watchdog running");
  a_sys_src_stops: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
    inSleep && wdtEn && !srcRc && !rstPinLow |=> $stable(presc_q))
    else $error("system-clock watchdog counted in power-down");
  a_int_block_capture: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE13
    sleepGo |=> intBlock_q == $past(intReq)) else $error("pending requests not captured at sleep");

endmodule // pdw_top
`default_nettype wire

/* verilog/pdw_fix_note.sv */
// No logic here: the whole block lives in pdw_top
`default_nettype none
`default_nettype wire

/* test/pdw_core_model.sv */
// Core model that issues sleep and watchdog clear instructions
`default_nettype none
module pdw_core_model (
  input  wire logic sys_clk,
  input  wire logic coreHold_q,
  output var  logic sleepExec,
  output var  logic clrSingle,
  output var  logic clrFirst,
  output var  logic clrSecond
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Instruction issue
  // ****************************************
  initial begin
    {sleepExec, clrSingle, clrFirst, clrSecond} = 4'h0;
  end
  // Kind 0 sleep, 1 single, 2 first half, 3 second half
  // A held core executes nothing, so it waits for the hold to drop
  task automatic exec(input int kind);
    int n;
    n = 0;
    while (coreHold_q !== 1'b0 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    sleepExec <= (kind == 0);
    clrSingle <= (kind == 1);
    clrFirst  <= (kind == 2);
    clrSecond <= (kind == 3);
    @(posedge sys_clk);
    {sleepExec, clrSingle, clrFirst, clrSecond} <= 4'h0;
  endtask
endmodule // pdw_core_model
`default_nettype wire

/* test/power_down_wake_watchdog_test.sv */
// Self-checking bench for the power-down, wake-up and watchdog block
`default_nettype none
module power_down_wake_watchdog_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, sys_rst, regWr, regRd, extRst_n, wdtOscPin, stackFull, rcOn;
  logic [7:0]  regAddr, regWdata, portA, rdv, regRdata_q;
  logic [15:0] portHi;
  logic [3:0]  intReq, intEnable;
  logic        sleepExec, clrSingle, clrFirst, clrSecond;
  logic        sysOscRun_q, rcOscRun_q, coreHold_q, chipReset_q, pcSpReset_q;
  logic        intVector_q, resume_q, timeoutFlag_q, powerdownFlag_q;
  int          n_errors, checks, wcnt, nRst, mTo, mPdf, k;

  pdw_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .sleepExec(sleepExec), .clrSingle(clrSingle),
    .clrFirst(clrFirst), .clrSecond(clrSecond), .extRst_n(extRst_n), .wdtOscPin(wdtOscPin),
    .portA(portA), .portHi(portHi), .intReq(intReq), .intEnable(intEnable),
    .stackFull(stackFull), .regRdata_q(regRdata_q), .sysOscRun_q(sysOscRun_q),
    .rcOscRun_q(rcOscRun_q), .coreHold_q(coreHold_q), .chipReset_q(chipReset_q),
    .pcSpReset_q(pcSpReset_q), .intVector_q(intVector_q), .resume_q(resume_q),
    .timeoutFlag_q(timeoutFlag_q), .powerdownFlag_q(powerdownFlag_q));
  pdw_core_model core (.sys_clk(sys_clk), .coreHold_q(coreHold_q), .sleepExec(sleepExec),
    .clrSingle(clrSingle), .clrFirst(clrFirst), .clrSecond(clrSecond));

  // ****************************************
  // Clocks, counters and shared tasks
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Slow RC clock, gated so the watchdog only ticks where a test wants it
  always begin
    repeat (4) @(posedge sys_clk);
    if (rcOn) wdtOscPin <= ~wdtOscPin;
  end
  // Cycles with the oscillator restarted but the core still held
  always @(posedge sys_clk) begin
    if (sysOscRun_q === 1'b1 && coreHold_q === 1'b1) wcnt++;
    if (chipReset_q === 1'b1) nRst++;
  end
  task automatic chk8(input logic [7:0] e, input logic [7:0] a);
    checks++;
    if (a !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic chkN(input int e, input int a);
    checks++;
    if (a != e) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    rdv = regRdata_q;
  endtask
  task automatic pins(input logic [7:0] a, input logic [15:0] h);
    @(posedge sys_clk);
    portA <= a;
    portHi <= h;
  endtask
  task automatic flags();
    chk8(8'(mPdf * 2 + mTo), {6'h00, powerdownFlag_q, timeoutFlag_q});
  endtask
  task automatic sleep();
    core.exec(0);
    @(negedge sys_clk);
    mTo = 0;
    mPdf = 1;
    flags();
    chk8(8'h00, {7'h00, sysOscRun_q});
    chk8(8'h01, {7'h00, rcOscRun_q});
    rd(pdw_pkg::ADDR_STATUS);
    chk8(8'h06, rdv);
  endtask
  // Code 0 resume, 1 vector, 2 PC and SP reset, 3 full reset
  task automatic waitWake(input int eCode, input int eCnt);
    int code;
    code = -1;
    wcnt = 0;
    for (int i = 0; i < 5000 && code < 0; i++) begin
      @(negedge sys_clk);
      if (resume_q === 1'b1) code = 0;
      else if (intVector_q === 1'b1) code = 1;
      else if (pcSpReset_q === 1'b1) code = 2;
      else if (chipReset_q === 1'b1) code = 3;
    end
    chkN(eCode, code);
    chkN(eCnt, wcnt);
  endtask
  task automatic results();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    results();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {sys_rst, extRst_n, portA, portHi} = {1'b1, 1'b1, 8'hFF, 16'hFFFF};
    {regWr, regRd, regAddr, regWdata, wdtOscPin, stackFull, rcOn} = '0;
    {intReq, intEnable, n_errors, checks, wcnt, nRst, mTo, mPdf} = '0;
    k = $urandom(68);
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(pdw_pkg::ADDR_CONFIG);
    chk8({4'h0, pdw_pkg::CFG_RESET}, rdv);
    rd(8'h14);
    chk8(8'h00, rdv);
    flags();
    k = $urandom % 8;
    wr(pdw_pkg::ADDR_WAKE_A, 8'h01 << k);
    sleep();
    pins(~(8'h01 << ((k + 1) % 8)), 16'hFFFF);
    repeat (20) @(negedge sys_clk);
    chk8(8'h01, {7'h00, coreHold_q});
    pins(~(8'h01 << k), 16'hFFFF);
    waitWake(0, 1024);
    pins(8'hFF, 16'hFFFF);
    flags();
    rd(pdw_pkg::ADDR_WAKE_A);
    chk8(8'h01 << k, rdv);
    k = $urandom % 4;
    wr(pdw_pkg::ADDR_WAKE_NB, 8'h01 << k);
    sleep();
    pins(8'hFF, ~(16'h0001 << (4 * k + $urandom % 4)));
    waitWake(0, 1024);
    pins(8'hFF, 16'hFFFF);
    @(posedge sys_clk);
    intReq <= 4'h1;
    intEnable <= 4'($urandom) | 4'h2;
    sleep();
    repeat (20) @(negedge sys_clk);
    chk8(8'h01, {7'h00, coreHold_q});
    @(posedge sys_clk);
    intReq <= 4'h3;
    waitWake(1, 1025);
    @(posedge sys_clk);
    {intReq, stackFull} <= 5'h03;
    sleep();
    @(posedge sys_clk);
    intReq <= 4'h3;
    waitWake(0, 1024);
    @(posedge sys_clk);
    {intReq, stackFull} <= 5'h00;
    wr(pdw_pkg::ADDR_CONFIG, 8'h0C);
    core.exec(1);
    @(negedge sys_clk);
    flags();
    wr(pdw_pkg::ADDR_CONFIG, 8'h0D);
    core.exec(1);
    @(negedge sys_clk);
    mPdf = 0;
    flags();
    wr(pdw_pkg::ADDR_CONFIG, 8'h09);
    core.exec(1);
    k = 0;
    while (chipReset_q !== 1'b1 && k < 300) begin
      @(negedge sys_clk);
      k++;
    end
    chk8(8'h01, {7'h00, k >= 64 && k <= 130});
    mTo = 1;
    flags();
    wr(pdw_pkg::ADDR_CONFIG, 8'h0B);
    @(negedge sys_clk);
    nRst = 0;
    repeat (8) begin
      core.exec(2);
      repeat (40) @(posedge sys_clk);
    end
    chk8(8'h01, {7'h00, nRst > 0});
    core.exec(3);
    @(negedge sys_clk);
    nRst = 0;
    for (int i = 0; i < 8; i++) begin
      core.exec(i % 2 ? 2 : 3);
      core.exec(i % 2 ? 3 : 2);
      repeat (30) @(posedge sys_clk);
    end
    chkN(0, nRst);
    wr(pdw_pkg::ADDR_CONFIG, 8'h0D);
    rcOn = 1;
    sleep();
    waitWake(2, 1024);
    mTo = 1;
    flags();
    rcOn = 0;
    wr(pdw_pkg::ADDR_CONFIG, 8'h09);
    sleep();
    repeat (300) @(negedge sys_clk);
    chk8(8'h01, {7'h00, coreHold_q});
    @(posedge sys_clk);
    extRst_n <= 1'b0;
    @(posedge sys_clk);
    extRst_n <= 1'b1;
    waitWake(3, 1024);
    {mTo, mPdf} = '0;
    flags();
    k = $urandom % 256;
    wr(pdw_pkg::ADDR_AUX, 8'(k));
    rd(pdw_pkg::ADDR_AUX);
    chk8(8'(k), rdv);
    rd(pdw_pkg::ADDR_AUX);
    chk8(8'(k) & 8'h1F, rdv);
    wr(pdw_pkg::ADDR_CONFIG, 8'h05);
    repeat (2) @(negedge sys_clk);
    chk8(8'h00, {7'h00, rcOscRun_q});
    @(posedge sys_clk);
    extRst_n <= 1'b0;
    @(posedge sys_clk);
    extRst_n <= 1'b1;
    nRst = 0;
    repeat (6) @(negedge sys_clk);
    chkN(1, nRst);
    results();
  end
endmodule // power_down_wake_watchdog_test
`default_nettype wire
